/* File: src/acl_pkg.sv */
// package: setup byte layout, defaults, codes and decode helpers for the configuration loader
package acl_pkg;

  localparam int          CFG_W          = 8;
  localparam int          MODE_HI        = 7;
  localparam int          MODE_LO        = 6;
  localparam int          REF_HI         = 5;
  localparam int          REF_LO         = 4;
  localparam int          PWR_BIT        = 3;
  localparam int          RSVD_HI        = 2;
  localparam int          RES_W          = 16;

  localparam logic [7:0]  CFG_DEFAULT    = 8'h00;
  localparam logic [7:0]  CFG_RSVD_MASK  = 8'h07;
  localparam logic [3:0]  BITS_PER_WRITE = 4'h8;
  localparam logic [3:0]  CNT_FIRST      = 4'h1;
  localparam logic [3:0]  CNT_STEP       = 4'h1;

  // output interface mode codes
  localparam logic [1:0]  IF_SEL_NOBUSY   = 2'h0;
  localparam logic [1:0]  IF_SEL_BUSY     = 2'h1;
  localparam logic [1:0]  IF_CHAIN_NOBUSY = 2'h2;
  localparam logic [1:0]  IF_CHAIN_BUSY   = 2'h3;

  // reference mode codes
  localparam logic [1:0]  REF_INT_BUF    = 2'h0;
  localparam logic [1:0]  REF_EXT_BUF    = 2'h1;
  localparam logic [1:0]  REF_INT_NOBUF  = 2'h2;
  localparam logic [1:0]  REF_EXT_NOBUF  = 2'h3;

  // straight binary result: flipping the msb of the core's two's complement value
  localparam logic [15:0] RES_MSB_FLIP   = 16'h8000;

  // serial clock limit the host keeps to
  localparam int          SCLK_MAX_MHZ   = 50;

  typedef enum logic [1:0]
  {
    ACL_LD_IDLE,
    ACL_LD_STAGED,
    ACL_LD_CLOSED
  } acl_ld_e;

  function automatic logic acl_ref_core_on(input logic [1:0] code);
    return (code == REF_INT_BUF) || (code == REF_INT_NOBUF);
  endfunction

  function automatic logic acl_ref_buf_on(input logic [1:0] code);
    return (code == REF_INT_BUF) || (code == REF_EXT_BUF);
  endfunction

  function automatic logic [15:0] acl_to_straight(input logic [15:0] twos);
    return twos ^ RES_MSB_FLIP;
  endfunction

endpackage

/* File: src/acl_sync2.sv */
// two flip-flop level synchroniser
module acl_sync2 (
  input  wire logic i_clk,
  input  wire logic i_d,
  output logic      o_q
);

  typedef struct packed
  {
    logic meta;
    logic q;
  } acl_sync_s;

  acl_sync_s st_r;
  acl_sync_s st_nxt;

  always_comb
  begin
    st_nxt.meta = i_d;
    st_nxt.q    = st_r.meta;
  end

  always_ff @(posedge i_clk)
  begin
    st_r <= st_nxt;
  end

  assign o_q = st_r.q;

endmodule

/* File: src/acl_shift.sv */
// serial-clock domain: write detection and eight-bit capture of the setup byte
module acl_shift (
  input  wire logic       i_sclk,
  input  wire logic       i_rstn_link,
  input  wire logic       i_conversion_start_line,
  input  wire logic       i_din,
  output logic [7:0]      o_word,
  output logic            o_done_tok,
  output logic            o_active
);

  typedef struct packed
  {
    logic       active;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] word;
    logic       done_tok;
  } acl_shift_s;

  acl_shift_s st_r;
  acl_shift_s st_nxt;
  logic       hi_at_rise_r;
  logic       start;
  logic [7:0] shifted;

  // the start line is driven by the host in step with the serial clock, so it is not resynchronised here
  always_ff @(posedge i_sclk)
  begin
    if (!i_rstn_link)
      hi_at_rise_r <= 1'b0;
    else
      hi_at_rise_r <= i_conversion_start_line;
  end

  // high at the rising edge and low at the next falling edge: it fell while the clock was high
  assign start   = hi_at_rise_r && !i_conversion_start_line;
  assign shifted = {st_r.shreg[6:0], i_din};

  always_comb
  begin
    st_nxt = st_r;
    if (i_conversion_start_line)
    begin
      st_nxt.active = 1'b0;
    end
    else if (start)
    begin
      st_nxt.active = 1'b1;
      st_nxt.cnt    = acl_pkg::CNT_FIRST;
      st_nxt.shreg  = shifted;
    end
    else if (st_r.active && (st_r.cnt < acl_pkg::BITS_PER_WRITE))
    begin
      st_nxt.shreg = shifted;
      st_nxt.cnt   = 4'(st_r.cnt + acl_pkg::CNT_STEP);
      if (4'(st_r.cnt + acl_pkg::CNT_STEP) == acl_pkg::BITS_PER_WRITE)
      begin
        st_nxt.word     = shifted;
        st_nxt.done_tok = ~st_r.done_tok;
      end
    end
  end

  always_ff @(negedge i_sclk)
  begin
    if (!i_rstn_link)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_word     = st_r.word;
  assign o_done_tok = st_r.done_tok;
  assign o_active   = st_r.active;

  sequence s_start;
    start;
  endsequence

  sequence s_eight_bits;
    s_start ##1 (!i_conversion_start_line) [*7];
  endsequence

  property p_no_false_start;
    @(negedge i_sclk) disable iff (!i_rstn_link)
      (!st_r.active && !hi_at_rise_r) |=> !st_r.active;
  endproperty
  a_no_false_start: assert property (p_no_false_start) else $error("write began without a high clock");

  property p_bit_on_fall;
    @(negedge i_sclk) disable iff (!i_rstn_link)
      (st_r.active && (st_r.cnt < acl_pkg::BITS_PER_WRITE) && !i_conversion_start_line)
      |=> (st_r.shreg[0] == $past(i_din));
  endproperty
  a_bit_on_fall: assert property (p_bit_on_fall) else $error("data bit not taken on falling edge");

  property p_msb_first;
    @(negedge i_sclk) disable iff (!i_rstn_link)
      s_eight_bits |=> (o_word == {$past(i_din, 8), $past(i_din, 7), $past(i_din, 6), $past(i_din, 5),
                                   $past(i_din, 4), $past(i_din, 3), $past(i_din, 2), $past(i_din, 1)});
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("byte not loaded msb first");

  property p_exactly_eight;
    @(negedge i_sclk) disable iff (!i_rstn_link)
      (st_r.cnt == acl_pkg::BITS_PER_WRITE && !start) |=> ($stable(o_word) && $stable(o_done_tok));
  endproperty
  a_exactly_eight: assert property (p_exactly_eight) else $error("extra clock edge changed the byte");

endmodule

/* File: src/acl_loader.sv */
// configuration loader top: serial setup port, staged apply and converter result formatting
// Operation
// - Each setup bit is taken from the data input on a falling serial clock edge.
// - A write begins only when the start line falls while the serial clock is held high.
// - Exactly the next eight bits after the start are shifted in, msb first, one per falling edge.
// - Bits 7:6 choose the output interface mode, defaulting to 00.
// - Bits 5:4 choose the reference mode; 00 runs reference and buffer, 01 runs only the buffer.
// - Reference code 10 runs only the internal reference and code 11 turns both off.
// - Bit 3 set puts the device in static shutdown with all circuitry off; clear keeps it powered.
// - Results are sixteen-bit straight binary, zero at 0000, midscale at 8000, full scale at FFFF.
// - A new setup takes effect from the conversion after the load has been completed.
// - Shutdown through the power bit also returns every setup field to its default.
module acl_loader (
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic        i_sclk,
  input  wire logic        i_conversion_start_line,
  input  wire logic        i_din,
  input  wire logic [15:0] i_conv_twos,
  input  wire logic        i_conv_done,
  output logic [1:0]       o_mode,
  output logic             o_ref_core_on,
  output logic             o_ref_buf_on,
  output logic             o_power_down_bit,
  output logic             o_cfg_staged,
  output logic [15:0]      o_result,
  output logic             o_result_valid
);

  typedef struct packed
  {
    acl_pkg::acl_ld_e ld;
    logic             tok_seen;
    logic             start_q;
    logic [7:0]       staged;
    logic [7:0]       live;
    logic             ref_core;
    logic             ref_buf;
    logic [15:0]      result;
    logic             rvalid;
  } acl_loader_s;

  acl_loader_s st_r;
  acl_loader_s st_nxt;

  logic       rstn_link;
  logic       start_s;
  logic       tok_s;
  logic [7:0] link_word;
  logic       link_tok;
  logic       start_rise;
  logic       new_load;
  logic [7:0] applied;

  // the serial-domain reset only takes hold once the serial clock has toggled a few times
  acl_sync2 u_rst_link (
    .i_clk (~i_sclk),
    .i_d   (i_rstn),
    .o_q   (rstn_link)
  );

  acl_shift u_shift (
    .i_sclk                  (i_sclk),
    .i_rstn_link             (rstn_link),
    .i_conversion_start_line (i_conversion_start_line),
    .i_din                   (i_din),
    .o_word                  (link_word),
    .o_done_tok              (link_tok),
    .o_active                ()
  );

  acl_sync2 u_sync_start (
    .i_clk (i_mclk),
    .i_d   (i_conversion_start_line),
    .o_q   (start_s)
  );

  acl_sync2 u_sync_tok (
    .i_clk (i_mclk),
    .i_d   (link_tok),
    .o_q   (tok_s)
  );

  assign start_rise = start_s && !st_r.start_q;
  // the byte stays still for many serial clocks after the toggle, so it is read here as a quasi-static word
  assign new_load   = (tok_s != st_r.tok_seen);

  // shutdown drops all fields to default; reserved bits never reach the logic
  always_comb
  begin
    applied = st_r.staged & ~acl_pkg::CFG_RSVD_MASK;
    if (st_r.staged[acl_pkg::PWR_BIT])
    begin
      applied                   = acl_pkg::CFG_DEFAULT;
      applied[acl_pkg::PWR_BIT] = 1'b1;
    end
  end

  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.start_q = start_s;
    st_nxt.rvalid  = 1'b0;

    case (st_r.ld)
      acl_pkg::ACL_LD_IDLE:
      begin
        if (new_load)
          st_nxt.ld = start_rise ? acl_pkg::ACL_LD_CLOSED : acl_pkg::ACL_LD_STAGED;
      end
      acl_pkg::ACL_LD_STAGED:
      begin
        // the rise that ends the write closes the load but starts a conversion that still runs on the old setup
        if (start_rise)
          st_nxt.ld = acl_pkg::ACL_LD_CLOSED;
      end
      acl_pkg::ACL_LD_CLOSED:
      begin
        if (start_rise)
        begin
          st_nxt.live     = applied;
          st_nxt.ref_core = !applied[acl_pkg::PWR_BIT]
                            && acl_pkg::acl_ref_core_on(applied[acl_pkg::REF_HI:acl_pkg::REF_LO]);
          st_nxt.ref_buf  = !applied[acl_pkg::PWR_BIT]
                            && acl_pkg::acl_ref_buf_on(applied[acl_pkg::REF_HI:acl_pkg::REF_LO]);
          st_nxt.ld       = acl_pkg::ACL_LD_IDLE;
        end
      end
      default:
      begin
        st_nxt.ld = acl_pkg::ACL_LD_IDLE;
      end
    endcase

    // a later write overrides an older staged byte that has not yet been applied
    if (new_load)
    begin
      st_nxt.tok_seen = tok_s;
      st_nxt.staged   = link_word;
      if (st_r.ld != acl_pkg::ACL_LD_IDLE)
        st_nxt.ld = start_rise ? acl_pkg::ACL_LD_CLOSED : acl_pkg::ACL_LD_STAGED;
    end

    // a converter in static shutdown produces nothing
    if (i_conv_done && !st_r.live[acl_pkg::PWR_BIT])
    begin
      st_nxt.result = acl_pkg::acl_to_straight(i_conv_twos);
      st_nxt.rvalid = 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      st_r          <= '0;
      st_r.ld       <= acl_pkg::ACL_LD_IDLE;
      st_r.live     <= acl_pkg::CFG_DEFAULT;
      st_r.staged   <= acl_pkg::CFG_DEFAULT;
      st_r.ref_core <= 1'b1;
      st_r.ref_buf  <= 1'b1;
      // idle level of the start line, so leaving reset shows no false rise
      st_r.start_q  <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_mode           = st_r.live[acl_pkg::MODE_HI:acl_pkg::MODE_LO];
  assign o_ref_core_on    = st_r.ref_core;
  assign o_ref_buf_on     = st_r.ref_buf;
  assign o_power_down_bit = st_r.live[acl_pkg::PWR_BIT];
  assign o_cfg_staged     = (st_r.ld != acl_pkg::ACL_LD_IDLE);
  assign o_result         = st_r.result;
  assign o_result_valid   = st_r.rvalid;

  sequence s_apply;
    (st_r.ld == acl_pkg::ACL_LD_CLOSED) && start_rise;
  endsequence

  sequence s_close;
    (st_r.ld == acl_pkg::ACL_LD_STAGED) && start_rise && !new_load;
  endsequence

  property p_wait_next_conv;
    @(posedge i_mclk) disable iff (!i_rstn)
      s_close |=> ($stable(st_r.live) && (st_r.ld == acl_pkg::ACL_LD_CLOSED));
  endproperty
  a_wait_next_conv: assert property (p_wait_next_conv) else $error("setup applied in the writing cycle");

  property p_apply_next;
    @(posedge i_mclk) disable iff (!i_rstn)
      (s_apply and !st_r.staged[acl_pkg::PWR_BIT]) |=>
        (st_r.live == ($past(st_r.staged) & ~acl_pkg::CFG_RSVD_MASK));
  endproperty
  a_apply_next: assert property (p_apply_next) else $error("staged setup not applied at next conversion");

  property p_mode_taken;
    @(posedge i_mclk) disable iff (!i_rstn)
      (s_apply and !st_r.staged[acl_pkg::PWR_BIT]) |=>
        (o_mode == $past(st_r.staged[acl_pkg::MODE_HI:acl_pkg::MODE_LO]));
  endproperty
  a_mode_taken: assert property (p_mode_taken) else $error("interface mode not taken from bits 7:6");

  property p_sleep_defaults;
    @(posedge i_mclk) disable iff (!i_rstn)
      (s_apply and st_r.staged[acl_pkg::PWR_BIT]) |=>
        (o_power_down_bit && (o_mode == acl_pkg::IF_SEL_NOBUSY)
         && (st_r.live[acl_pkg::REF_HI:acl_pkg::REF_LO] == acl_pkg::REF_INT_BUF));
  endproperty
  a_sleep_defaults: assert property (p_sleep_defaults) else $error("shutdown kept non-default fields");

  property p_ref_ext_buf;
    @(posedge i_mclk) disable iff (!i_rstn)
      (!o_power_down_bit && (st_r.live[acl_pkg::REF_HI:acl_pkg::REF_LO] == acl_pkg::REF_EXT_BUF))
        |-> (o_ref_buf_on && !o_ref_core_on);
  endproperty
  a_ref_ext_buf: assert property (p_ref_ext_buf) else $error("reference code 01 decoded wrongly");

  property p_ref_int_buf;
    @(posedge i_mclk) disable iff (!i_rstn)
      (!o_power_down_bit && (st_r.live[acl_pkg::REF_HI:acl_pkg::REF_LO] == acl_pkg::REF_INT_BUF))
        |-> (o_ref_buf_on && o_ref_core_on);
  endproperty
  a_ref_int_buf: assert property (p_ref_int_buf) else $error("reference code 00 decoded wrongly");

  property p_ref_nobuf;
    @(posedge i_mclk) disable iff (!i_rstn)
      (st_r.live[acl_pkg::REF_HI:acl_pkg::REF_LO] == acl_pkg::REF_INT_NOBUF)
        |-> (!o_ref_buf_on && (o_ref_core_on == !o_power_down_bit));
  endproperty
  a_ref_nobuf: assert property (p_ref_nobuf) else $error("reference code 10 decoded wrongly");

  property p_ref_all_off;
    @(posedge i_mclk) disable iff (!i_rstn)
      (st_r.live[acl_pkg::REF_HI:acl_pkg::REF_LO] == acl_pkg::REF_EXT_NOBUF) |-> (!o_ref_buf_on && !o_ref_core_on);
  endproperty
  a_ref_all_off: assert property (p_ref_all_off) else $error("reference code 11 left circuitry on");

  property p_sleep_quiet;
    @(posedge i_mclk) disable iff (!i_rstn)
      (o_power_down_bit && $past(o_power_down_bit)) |-> (!o_ref_core_on && !o_ref_buf_on && !o_result_valid);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("circuitry active in static shutdown");

  property p_straight_binary;
    @(posedge i_mclk) disable iff (!i_rstn)
      (i_conv_done && !o_power_down_bit) |=>
        (o_result_valid && (o_result == {~$past(i_conv_twos[15]), $past(i_conv_twos[14:0])}));
  endproperty
  a_straight_binary: assert property (p_straight_binary) else $error("result not straight binary");

  property p_staged_flag;
    @(posedge i_mclk) disable iff (!i_rstn)
      new_load |=> o_cfg_staged;
  endproperty
  a_staged_flag: assert property (p_staged_flag) else $error("landed byte not marked as staged");

  property p_staged_clears;
    @(posedge i_mclk) disable iff (!i_rstn)
      (s_apply and !new_load) |=> !o_cfg_staged;
  endproperty
  a_staged_clears: assert property (p_staged_clears) else $error("staged flag kept after the apply");

  property p_live_on_conv;
    @(posedge i_mclk) disable iff (!i_rstn)
      !start_rise |=> $stable(st_r.live);
  endproperty
  a_live_on_conv: assert property (p_live_on_conv) else $error("setup changed outside a conversion start");

  property p_rsvd_clear;
    @(posedge i_mclk) disable iff (!i_rstn)
      s_apply |=> ((st_r.live & acl_pkg::CFG_RSVD_MASK) == 8'h00);
  endproperty
  a_rsvd_clear: assert property (p_rsvd_clear) else $error("reserved bits reached the applied setup");

  property p_sleep_no_result;
    @(posedge i_mclk) disable iff (!i_rstn)
      (i_conv_done && o_power_down_bit) |=> !o_result_valid;
  endproperty
  a_sleep_no_result: assert property (p_sleep_no_result) else $error("result given in static shutdown");

  property p_ref_off_asleep;
    @(posedge i_mclk) disable iff (!i_rstn)
      o_power_down_bit |-> (!o_ref_core_on && !o_ref_buf_on);
  endproperty
  a_ref_off_asleep: assert property (p_ref_off_asleep) else $error("reference powered in shutdown");

  property p_valid_pulse;
    @(posedge i_mclk) disable iff (!i_rstn)
      !i_conv_done |=> !o_result_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("result valid without a finished conversion");

  property p_result_hold;
    @(posedge i_mclk) disable iff (!i_rstn)
      !i_conv_done |=> $stable(o_result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed without a finished conversion");

endmodule

/* File: sim/acl_host_model.sv */
// host side model: drives the serial clock, start line and setup data
module acl_host_model (
  output logic o_sclk,
  output logic o_conversion_start_line,
  output logic o_din
);
  timeunit 1ns;
  timeprecision 1ps;

  // 80 ns period keeps the link well under its 50 MHz ceiling
  localparam int HALF = 40;

  initial
  begin
    o_sclk = 1'b0;
    o_conversion_start_line = 1'b1;
    o_din = 1'b1;
  end

  task automatic run_clocks(input int n);
    repeat (n)
    begin
      #HALF o_sclk = 1'b1;
      #HALF o_sclk = 1'b0;
    end
  endtask

  // n bits msb first; bits past the eighth are zeros; the clock stands low outside frames
  task automatic write_bits(input logic [7:0] b, input int n);
    #HALF o_sclk = 1'b1;
    #(HALF/2) o_conversion_start_line = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      o_din = (i < 8) ? b[7-i] : 1'b0;
      #(HALF/2) o_sclk = 1'b0;
      #HALF o_sclk = 1'b1;
      #(HALF/2);
    end
    // raised while the clock is high so a short write gets no extra fall
    o_conversion_start_line = 1'b1;
    o_din = 1'b1;
    #(HALF/2) o_sclk = 1'b0;
    #HALF;
  endtask

  // clock held low, so this low pulse is a plain conversion start
  task automatic convert();
    o_conversion_start_line = 1'b0;
    #400 o_conversion_start_line = 1'b1;
    #800;
  endtask
endmodule

/* File: sim/test_acl_loader.sv */
// self-checking bench for the setup byte loader
module test_acl_loader;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_mclk;
  logic        i_rstn;
  logic        sclk;
  logic        cnv;
  logic        din;
  logic [15:0] twos;
  logic        done;
  logic [1:0]  mode;
  logic        core_on;
  logic        buf_on;
  logic        pd;
  logic        staged;
  logic [15:0] result;
  logic        valid;
  logic [1:0]  e_mode;
  logic        e_core;
  logic        e_buf;
  logic        e_pd;
  int          err_total;
  int          comparisons;

  acl_host_model host (
    .o_sclk                  (sclk),
    .o_conversion_start_line (cnv),
    .o_din                   (din)
  );

  acl_loader uut (
    .i_mclk                  (i_mclk),
    .i_rstn                  (i_rstn),
    .i_sclk                  (sclk),
    .i_conversion_start_line (cnv),
    .i_din                   (din),
    .i_conv_twos             (twos),
    .i_conv_done             (done),
    .o_mode                  (mode),
    .o_ref_core_on           (core_on),
    .o_ref_buf_on            (buf_on),
    .o_power_down_bit        (pd),
    .o_cfg_staged            (staged),
    .o_result                (result),
    .o_result_valid          (valid)
  );

  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic report_and_stop();
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic fail(input string msg);
    err_total++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic set_exp(input logic [7:0] b);
    if (b[acl_pkg::PWR_BIT])
    begin
      e_mode = acl_pkg::IF_SEL_NOBUSY;
      e_core = 1'b0;
      e_buf  = 1'b0;
      e_pd   = 1'b1;
    end
    else
    begin
      e_mode = b[7:6];
      e_core = ~b[4];
      e_buf  = ~b[5];
      e_pd   = 1'b0;
    end
  endtask

  task automatic chk_cfg(input logic st);
    comparisons++;
    if (mode !== e_mode || core_on !== e_core || buf_on !== e_buf || pd !== e_pd || staged !== st)
      fail($sformatf("cfg mode %b ref %b%b pd %b staged %b", mode, core_on, buf_on, pd, staged));
  endtask

  task automatic chk_res(input logic v, input logic [15:0] r);
    comparisons++;
    if (valid !== v || result !== r)
      fail($sformatf("result %h valid %b, want %h %b", result, valid, r, v));
  endtask

  task automatic wait_staged();
    int n;
    n = 0;
    while (staged !== 1'b1)
    begin
      @(posedge i_mclk);
      #1;
      n++;
      if (n > 30)
      begin
        fail("staged flag never rose");
        report_and_stop();
      end
    end
  endtask

  // write, check the old setup survives the closing edge, then apply with a conversion
  task automatic load(input logic [7:0] b, input int n);
    host.write_bits(b, n);
    if (n >= 8)
    begin
      wait_staged();
      chk_cfg(1'b1);
      set_exp(b);
    end
    host.convert();
    chk_cfg(1'b0);
  endtask

  task automatic t_reset();
    set_exp(acl_pkg::CFG_DEFAULT);
    chk_cfg(1'b0);
    chk_res(1'b0, 16'h0000);
  endtask

  // every mode and reference code, reserved bits zero
  task automatic t_codes();
    for (int i = 0; i < 16; i++)
      load({i[3:0], 4'h0}, 8);
  endtask

  task automatic t_short_long();
    load(8'hC0, 5);
    load(8'h90, 11);
  endtask

  // back-to-back conversions, then the pulse must drop
  task automatic t_result();
    logic [15:0] tw[4] = '{16'h8000, 16'h0000, 16'h7FFF, 16'h1234};
    logic [15:0] ex[4] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h9234};
    for (int i = 0; i <= 4; i++)
    begin
      @(posedge i_mclk);
      #1;
      if (i > 0)
        chk_res(1'b1, ex[i-1]);
      if (i < 4)
      begin
        done = 1'b1;
        twos = tw[i];
      end
      else
        done = 1'b0;
    end
    @(posedge i_mclk);
    #1;
    chk_res(1'b0, 16'h9234);
  endtask

  task automatic t_shutdown();
    load(8'hF8, 8);
    @(posedge i_mclk);
    #1;
    done = 1'b1;
    twos = 16'h0001;
    @(posedge i_mclk);
    #1;
    done = 1'b0;
    chk_res(1'b0, 16'h9234);
    load(8'h60, 8);
  endtask

  initial
  begin
    err_total = 0;
    comparisons = 0;
    i_rstn = 1'b0;
    done = 1'b0;
    twos = 16'h0000;
    fork
      host.run_clocks(4);
    join_none
    repeat (5) @(posedge i_mclk);
    #1;
    i_rstn = 1'b1;
    host.run_clocks(3);
    t_reset();
    t_codes();
    t_short_long();
    t_result();
    t_shutdown();
    report_and_stop();
  end
endmodule
